// ---- logic/dimp_core.sv ----
// Summary of operation
// - loop reset needs 200 cycles before lock
// - clock change demands new reset and 200 cycles
// - all four strobes low with enable high
// - load sampled address and bank pins
// - burst length, type and latency fields
// - latency 3 or 2.5, others reserved
// - burst length 2, 4, 8, others reserved
// - bit 7 test, bit 8 loop reset
// - bank select 0 high selects extended register
// - extended bit 0 at DLL_EN_LEVEL, low by default, enables the loop
// - extended bits 1 and 6 set drive
`include "dimp_map.svh"
`timescale 1ns/10ps
`default_nettype none

module dimp_core #(
  parameter int         LOCK_CYCLES  = `DIMP_DLL_LOCK_CYCLES,
  parameter logic       DLL_EN_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                nrst_i,
  // Command and address pins of the memory
  input  wire logic                cke_i,
  input  wire logic                cs_n_i,
  input  wire logic                ras_n_i,
  input  wire logic                cas_n_i,
  input  wire logic                we_n_i,
  input  wire logic                bank_sel0_i,
  input  wire logic                bank_sel1_i,
  input  wire dimp_pkg::dimp_addr_t addr_i,
  // Decoded operating mode
  output var  logic [3:0]          burst_len_o,
  output var  logic                burst_interleave_o,
  output var  logic [2:0]          read_lat_half_o,
  output var  logic                test_mode_o,
  output var  logic                dll_enable_o,
  output var  logic [1:0]          drive_code_o,
  output var  logic                dll_locked_o,
  output var  logic                init_done_o,
  // AXI4-Lite write channels
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import dimp_pkg::*;

  initial begin
    // The lock-wait check needs eight quiet cycles after a loop reset
    if (LOCK_CYCLES < 9 || LOCK_CYCLES > 255) $error("dimp_core: LOCK_CYCLES out of 9..255");
  end

  // ==========================================================================
  // Pin synchronisers
  logic [19:0] pins_s;
  logic        cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, bs0_s, bs1_s;
  dimp_addr_t  addr_s;

  dimp_sync #(.WIDTH(20)) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i ({cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_sel1_i, bank_sel0_i, addr_i}),
    .sync_o  (pins_s)
  );
  assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, bs1_s, bs0_s, addr_s} = pins_s;

  // ==========================================================================
  // Command decode
  logic       cke_prev;
  logic       dec_en;
  logic       cke_ok, set_any, mode_set_cmd, ext_mode_set_cmd, pre_all, refresh, cmd_any;
  dimp_mreg_t mode_reg, ext_reg;
  logic [1:0] gap;
  logic [1:0] ref_cnt;
  logic [7:0] lock_cnt;
  logic       locking;
  logic       freq_chg;
  logic [3:0] err;
  logic [3:0] err_clr;
  dimp_init_t state;
  logic       pre2_seen, rst_seen;

  // Clock enable must have been high in the previous cycle as well
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= cke_s;
    end
  end

  assign cke_ok           = cke_s && cke_prev && dec_en;
  assign set_any          = cke_ok && !cs_n_s && !ras_n_s && !cas_n_s && !we_n_s;
  assign mode_set_cmd     = set_any && !bs0_s;
  assign ext_mode_set_cmd = set_any && bs0_s;
  assign pre_all          = cke_ok && !cs_n_s && !ras_n_s && cas_n_s && !we_n_s && addr_s[`DIMP_AP_BIT];
  assign refresh          = cke_ok && !cs_n_s && !ras_n_s && !cas_n_s && we_n_s;
  assign cmd_any          = cke_ok && !cs_n_s && !(ras_n_s && cas_n_s && we_n_s);

  // ==========================================================================
  // Mode and extended mode registers, loaded with the sampled pins
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg <= `DIMP_MREG_RST;
    end else if (mode_set_cmd) begin
      mode_reg <= {bs1_s, bs0_s, addr_s};
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_reg <= `DIMP_MREG_RST;
    end else if (ext_mode_set_cmd) begin
      ext_reg <= {bs1_s, bs0_s, addr_s};
    end
  end

  // ==========================================================================
  // Decoded mode outputs; reserved codes decode to zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_len_o        <= 4'h0;
      burst_interleave_o <= 1'b0;
      read_lat_half_o    <= 3'h0;
      test_mode_o        <= 1'b0;
    end else begin
      case (mode_reg[`DIMP_BL_MSB:0])
        `DIMP_BL_CODE_2: burst_len_o <= 4'h2;
        `DIMP_BL_CODE_4: burst_len_o <= 4'h4;
        `DIMP_BL_CODE_8: burst_len_o <= 4'h8;
        default:         burst_len_o <= 4'h0;
      endcase
      burst_interleave_o <= mode_reg[`DIMP_BT_BIT];
      case (mode_reg[`DIMP_RL_MSB:`DIMP_RL_LSB])
        `DIMP_RL_CODE_3:   read_lat_half_o <= `DIMP_RL_HALF_3;
        `DIMP_RL_CODE_2P5: read_lat_half_o <= `DIMP_RL_HALF_2P5;
        default:           read_lat_half_o <= 3'h0;
      endcase
      test_mode_o <= mode_reg[`DIMP_TEST_BIT];
    end
  end

  // Loop enable and driver strength; code polarity of drive kept raw
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dll_enable_o <= 1'b0;
      drive_code_o <= 2'h0;
    end else begin
      dll_enable_o <= (ext_reg[`DIMP_EXT_DLL_BIT] == DLL_EN_LEVEL);
      drive_code_o <= {ext_reg[`DIMP_EXT_DRV_HI], ext_reg[`DIMP_EXT_DRV_LO]};
    end
  end

  // ==========================================================================
  // Loop lock counter: a reset or a clock change forces a fresh wait
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      locking      <= 1'b0;
      dll_locked_o <= 1'b0;
      lock_cnt     <= 8'h00;
    end else if (freq_chg) begin
      locking      <= 1'b0;
      dll_locked_o <= 1'b0;
      lock_cnt     <= 8'h00;
    end else if (mode_set_cmd && addr_s[`DIMP_DLLRST_BIT]) begin
      locking      <= 1'b1;
      dll_locked_o <= 1'b0;
      lock_cnt     <= 8'h00;
    end else if (!dll_enable_o) begin
      locking      <= 1'b0;
      dll_locked_o <= 1'b0;
    end else if (locking) begin
      if (lock_cnt == 8'(LOCK_CYCLES - 1)) begin
        locking      <= 1'b0;
        dll_locked_o <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Spacing watch after a set command
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap <= 2'h0;
    end else if (set_any) begin
      gap <= 2'(`DIMP_MODE_GAP - 1);
    end else if (gap != 2'h0) begin
      gap <= gap - 2'h1;
    end
  end

  // Sticky faults; a new fault wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err <= 4'h0;
    end else begin
      err[0] <= (mode_set_cmd && addr_s[`DIMP_RL_MSB:`DIMP_RL_LSB] != `DIMP_RL_CODE_3
                 && addr_s[`DIMP_RL_MSB:`DIMP_RL_LSB] != `DIMP_RL_CODE_2P5) || (err[0] && !err_clr[0]);
      err[1] <= (mode_set_cmd && (addr_s[`DIMP_BL_MSB:0] == 3'h0 || addr_s[`DIMP_BL_MSB] == 1'b1))
                || (err[1] && !err_clr[1]);
      err[2] <= (cmd_any && gap != 2'h0) || (err[2] && !err_clr[2]);
      err[3] <= (ext_mode_set_cmd && (bs1_s || (addr_s & ~`DIMP_EXT_USED_MASK) != 13'h0000))
                || (err[3] && !err_clr[3]);
    end
  end

  // ==========================================================================
  // Power-up progress as observed on the pins
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state     <= DIMP_PWR;
      pre2_seen <= 1'b0;
      rst_seen  <= 1'b0;
      ref_cnt   <= 2'h0;
    end else begin
      case (state)
        DIMP_PWR: begin
          // A precharge in the very first enabled cycle must not be lost
          if (pre_all) begin
            state <= DIMP_WAIT_EXT;
          end else if (cke_ok) begin
            state <= DIMP_WAIT_PRE;
          end
        end
        DIMP_WAIT_PRE: begin
          if (pre_all) state <= DIMP_WAIT_EXT;
        end
        DIMP_WAIT_EXT: begin
          if (ext_mode_set_cmd && addr_s[`DIMP_EXT_DLL_BIT] == DLL_EN_LEVEL) begin
            state     <= DIMP_WAIT_MODE;
            pre2_seen <= 1'b0;
            rst_seen  <= 1'b0;
            ref_cnt   <= 2'h0;
          end
        end
        DIMP_WAIT_MODE: begin
          if (pre_all) pre2_seen <= 1'b1;
          if (refresh && pre2_seen && ref_cnt != 2'h3) ref_cnt <= ref_cnt + 2'h1;
          if (mode_set_cmd && addr_s[`DIMP_DLLRST_BIT]) rst_seen <= 1'b1;
          if (mode_set_cmd && !addr_s[`DIMP_DLLRST_BIT] && rst_seen && pre2_seen
              && ref_cnt >= 2'(`DIMP_MIN_REFRESH)) begin
            state <= DIMP_READY;
          end
        end
        DIMP_READY: begin
          state <= DIMP_READY;
        end
        default: begin
          state <= DIMP_PWR;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_done_o <= 1'b0;
    end else begin
      init_done_o <= (state == DIMP_READY);
    end
  end

  // ==========================================================================
  // AXI4-Lite slave; address and data are held until both are in
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic [31:0] rd_mux;
  logic        wr_ok;

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ok   = (aw_addr == `DIMP_REG_CTRL) || (aw_addr == `DIMP_REG_STATUS)
                   || (aw_addr == `DIMP_REG_MODE) || (aw_addr == `DIMP_REG_EXT);
  assign err_clr = (wr_fire && aw_addr == `DIMP_REG_STATUS && w_strb[0]) ? w_data[3:0] : 4'h0;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control: decode enable is stored, clock change is a one-cycle pulse
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dec_en   <= 1'(`DIMP_CTRL_RST);
      freq_chg <= 1'b0;
    end else begin
      freq_chg <= wr_fire && aw_addr == `DIMP_REG_CTRL && w_strb[0] && w_data[`DIMP_CTRL_CLK_CHG];
      if (wr_fire && aw_addr == `DIMP_REG_CTRL && w_strb[0]) begin
        dec_en <= w_data[`DIMP_CTRL_DEC_EN];
      end
    end
  end

  // Read data mux; unmapped words read zero with a slave error
  always_comb begin
    rd_mux = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      `DIMP_REG_CTRL:   rd_mux = {31'h0, dec_en};
      `DIMP_REG_STATUS: rd_mux = {19'h0, state, init_done_o, dll_locked_o, 4'h0, err};
      `DIMP_REG_MODE:   rd_mux = {17'h0, mode_reg};
      `DIMP_REG_EXT:    rd_mux = {17'h0, ext_reg};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= (s_axi_araddr[7:4] == 4'h0) ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  property p_mode_load;
    @(posedge clock_i) disable iff (!nrst_i)
    mode_set_cmd |=> (mode_reg == $past({bs1_s, bs0_s, addr_s})) && $stable(ext_reg);
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("mode register did not take the sampled pins");

  property p_ext_load;
    @(posedge clock_i) disable iff (!nrst_i)
    ext_mode_set_cmd |=> (ext_reg == $past({bs1_s, bs0_s, addr_s})) && $stable(mode_reg);
  endproperty
  a_ext_load: assert property (p_ext_load)
    else $error("extended register did not take the sampled pins");

  property p_lock_wait;
    @(posedge clock_i) disable iff (!nrst_i)
    (mode_set_cmd && addr_s[`DIMP_DLLRST_BIT]) |=> !dll_locked_o [*8];
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("lock reported too soon after loop reset");

  property p_lock_count;
    @(posedge clock_i) disable iff (!nrst_i)
    $rose(dll_locked_o) |-> $past(lock_cnt) == 8'(LOCK_CYCLES - 1) && $past(locking);
  endproperty
  a_lock_count: assert property (p_lock_count)
    else $error("lock rose without the full count");

  property p_clk_change;
    @(posedge clock_i) disable iff (!nrst_i)
    freq_chg |=> !dll_locked_o && !locking;
  endproperty
  a_clk_change: assert property (p_clk_change)
    else $error("lock kept across a clock change");

  property p_burst_type;
    @(posedge clock_i) disable iff (!nrst_i)
    mode_set_cmd |-> ##2 burst_interleave_o == $past(addr_s[`DIMP_BT_BIT], 2);
  endproperty
  a_burst_type: assert property (p_burst_type)
    else $error("burst ordering does not follow bit 3");

  property p_latency;
    @(posedge clock_i) disable iff (!nrst_i)
    (mode_set_cmd && addr_s[`DIMP_RL_MSB:`DIMP_RL_LSB] == `DIMP_RL_CODE_2P5) |-> ##2 read_lat_half_o == 3'h5;
  endproperty
  a_latency: assert property (p_latency)
    else $error("latency 2.5 not decoded");

  property p_burst_len;
    @(posedge clock_i) disable iff (!nrst_i)
    (mode_set_cmd && addr_s[`DIMP_BL_MSB:0] == `DIMP_BL_CODE_8) |-> ##2 burst_len_o == 4'h8;
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst length 8 not decoded");

  property p_test_bit;
    @(posedge clock_i) disable iff (!nrst_i)
    mode_set_cmd |-> ##2 test_mode_o == $past(addr_s[`DIMP_TEST_BIT], 2);
  endproperty
  a_test_bit: assert property (p_test_bit)
    else $error("test mode does not follow bit 7");

  property p_ext_fields;
    @(posedge clock_i) disable iff (!nrst_i)
    ext_mode_set_cmd |-> ##2 (dll_enable_o == ($past(addr_s[0], 2) == DLL_EN_LEVEL))
                     && drive_code_o == {$past(addr_s[6], 2), $past(addr_s[1], 2)};
  endproperty
  a_ext_fields: assert property (p_ext_fields)
    else $error("extended fields not decoded");

endmodule

`default_nettype wire

// ---- logic/dimp_map.svh ----
`ifndef DIMP_MAP_SVH
`define DIMP_MAP_SVH

// ==========================================================================
// Register byte offsets
`define DIMP_REG_CTRL      8'h00
`define DIMP_REG_STATUS    8'h04
`define DIMP_REG_MODE      8'h08
`define DIMP_REG_EXT       8'h0C

// ==========================================================================
// Reset values
`define DIMP_CTRL_RST      2'h1
`define DIMP_MREG_RST      15'h0000

// ==========================================================================
// Field positions inside the control and status words
`define DIMP_CTRL_DEC_EN   0
`define DIMP_CTRL_CLK_CHG  1
`define DIMP_ST_LOCK       8
`define DIMP_ST_DONE       9
`define DIMP_ST_STATE_LSB  10

// ==========================================================================
// Address-pin fields of the mode and extended mode registers
`define DIMP_BL_MSB        2
`define DIMP_BT_BIT        3
`define DIMP_RL_LSB        4
`define DIMP_RL_MSB        6
`define DIMP_TEST_BIT      7
`define DIMP_DLLRST_BIT    8
`define DIMP_AP_BIT        10
`define DIMP_EXT_DLL_BIT   0
`define DIMP_EXT_DRV_LO    1
`define DIMP_EXT_DRV_HI    6
`define DIMP_EXT_USED_MASK 13'h0043

// ==========================================================================
// Codes
`define DIMP_BL_CODE_2     3'h1
`define DIMP_BL_CODE_4     3'h2
`define DIMP_BL_CODE_8     3'h3
`define DIMP_RL_CODE_3     3'h3
`define DIMP_RL_CODE_2P5   3'h6
`define DIMP_RL_HALF_3     3'h6
`define DIMP_RL_HALF_2P5   3'h5

// ==========================================================================
// Timing counts in clock cycles; the refresh minimum is a count of refresh commands
`define DIMP_DLL_LOCK_CYCLES 200
`define DIMP_MODE_GAP        2
`define DIMP_MIN_REFRESH     2

`endif

// ---- logic/dimp_pkg.sv ----
package dimp_pkg;
  // Progress of the power-up sequence as seen on the command pins
  typedef enum logic [2:0] {
    DIMP_PWR       = 3'b000,
    DIMP_WAIT_PRE  = 3'b001,
    DIMP_WAIT_EXT  = 3'b010,
    DIMP_WAIT_MODE = 3'b011,
    DIMP_READY     = 3'b100
  } dimp_init_t;

  typedef logic [12:0] dimp_addr_t;
  // Bank selects on top, address pins below
  typedef logic [14:0] dimp_mreg_t;
endpackage

// ---- logic/dimp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Two-flop synchroniser, one stage pair per bit
module dimp_sync #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  initial begin
    if (WIDTH < 1) $error("dimp_sync: WIDTH must be positive");
  end

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic meta;
      // The first stage feeds only the second
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta      <= 1'b0;
          sync_o[b] <= 1'b0;
        end else begin
          meta      <= async_i[b];
          sync_o[b] <= meta;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- verification/dimp_ctl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Memory controller side of the command and address pins
module dimp_ctl_model #(
  parameter int STABLE = 50000
) (
  // Clock
  input  wire logic        clock_i,
  // Command and address pins
  output var  logic        cke_o,
  output var  logic [3:0]  cmd_n_o,
  output var  logic [1:0]  bs_o,
  output var  logic [12:0] addr_o
);
  // Power-up state: enable low, chip deselected
  initial begin
    cke_o = 1'b0;
    cmd_n_o = 4'hF;
    bs_o = 2'h0;
    addr_o = 13'h0;
  end
  // One command, then no-ops; address flips so a stale value never looks valid
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(posedge clock_i);
    cmd_n_o <= c;
    bs_o <= b;
    addr_o <= a;
    repeat (6) begin
      @(posedge clock_i);
      cmd_n_o <= 4'h7;
      addr_o <= ~a;
    end
  endtask
  // Power-up order; refreshes follow the second precharge
  task automatic power_up(input logic [12:0] drv, input logic [12:0] mode);
    repeat (STABLE) @(posedge clock_i);
    cke_o <= 1'b1;
    cmd_n_o <= 4'h7;
    cmd(4'h2, 2'h0, 13'h0400);
    cmd(4'h0, 2'h1, drv);
    cmd(4'h0, 2'h0, mode | 13'h0100);
    cmd(4'h2, 2'h0, 13'h0400);
    cmd(4'h1, 2'h0, 13'h0000);
    cmd(4'h1, 2'h0, 13'h0000);
    cmd(4'h0, 2'h0, mode);
  endtask
endmodule
`default_nettype wire

// ---- verification/test_dram_init_mode_program.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Bench: pins from the controller model, registers over the bus
module test_dram_init_mode_program;
  import dimp_pkg::*;
  localparam int LOCK = 40;
  logic       clock_i, nrst_i, cke, bt, tm, de, lk, dn;
  logic [3:0] cmd_n, bl, wstrb;
  logic [1:0] bs, dc, bresp, rresp;
  logic [2:0] rl;
  dimp_addr_t addr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic       awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int         mismatches, checked;
  dimp_ctl_model #(.STABLE(100)) u_ctl (.clock_i(clock_i), .cke_o(cke), .cmd_n_o(cmd_n), .bs_o(bs), .addr_o(addr));
  dimp_core #(.LOCK_CYCLES(LOCK)) u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .cke_i(cke), .cs_n_i(cmd_n[3]),
    .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .bank_sel0_i(bs[0]), .bank_sel1_i(bs[1]),
    .addr_i(addr), .burst_len_o(bl), .burst_interleave_o(bt), .read_lat_half_o(rl), .test_mode_o(tm),
    .dll_enable_o(de), .drive_code_o(dc), .dll_locked_o(lk), .init_done_o(dn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ==========================================================================
  // Clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Verdict in one place
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A wait that ran out ends the run
  task automatic guard(input int n);
    if (n >= 200) begin
      mismatches++;
      $display("wrong value bus answer expected 1 seen 0");
      final_report();
    end
  endtask
  // ==========================================================================
  // Bus master: each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    // One edge between calls so no handshake signal is assigned twice in a step
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    guard(n);
    chk("write response", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    guard(n);
    chk("read data", ed, rdata);
    chk("read response", {30'h0, er}, {30'h0, rresp});
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {mismatches, checked, nrst_i, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h0C, 32'h0, 2'h0);
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    $display("test reset done");
    u_ctl.power_up(13'h0042, 13'h003B);
    chk("lock early", 0, lk);
    chk("loop enable", 1, de);
    chk("drive", 3, dc);
    chk("init done", 1, dn);
    rd(8'h0C, 32'h2042, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    rd(8'h08, 32'h003B, 2'h0);
    repeat (LOCK) @(posedge clock_i);
    rd(8'h04, 32'h1300, 2'h0);
    $display("test power up done");
    // Every burst and latency code, reserved ones too
    for (int i = 0; i < 8; i++) begin
      u_ctl.cmd(4'h0, 2'h0, {5'h0, i == 7, i[2:0], i[0], i[2:0]});
      chk("burst length", (i == 1) ? 2 : (i == 2) ? 4 : (i == 3) ? 8 : 0, bl);
      chk("read latency", (i == 3) ? 6 : (i == 6) ? 5 : 0, rl);
      chk("burst order", i % 2, bt);
      chk("test mode", i == 7, tm);
    end
    rd(8'h04, 32'h1303, 2'h0);
    // Without byte 0 enabled the clear must have no effect
    wstrb <= 4'h0;
    wr(8'h04, 32'hF, 2'h0);
    rd(8'h04, 32'h1303, 2'h0);
    wstrb <= 4'hF;
    wr(8'h04, 32'hF, 2'h0);
    rd(8'h04, 32'h1300, 2'h0);
    $display("test codes done");
    wr(8'h00, 32'h0, 2'h0);
    u_ctl.cmd(4'h0, 2'h0, 13'h003B);
    chk("decode off", 0, bl);
    wr(8'h00, 32'h1, 2'h0);
    u_ctl.cmd(4'h0, 2'h0, 13'h003B);
    chk("decode on", 8, bl);
    $display("test enable done");
    wr(8'h00, 32'h3, 2'h0);
    rd(8'h00, 32'h1, 2'h0);
    chk("lock dropped", 0, lk);
    u_ctl.cmd(4'h0, 2'h0, 13'h013B);
    chk("lock wait", 0, lk);
    repeat (LOCK) @(posedge clock_i);
    chk("lock again", 1, lk);
    $display("test relock done");
    final_report();
  end
endmodule
`default_nettype wire
